/* ssp_device.sv */
// Operation
// R1 - Bits sampled on serial clock rise, MSB first
// R2 - Shift only while load strobe is low
// R3 - Strobe rise moves word to selected register
// R4 - Two lowest positions select destination register
// R5 - Host loads mode word before others
// R6 - Reference ratio: 15 bits from position three; the code takes them from position two
// R7 - Host keeps reference ratio 3 to 32767
// R8 - Swallow 7 bits, then main 11 bits
// R9 - LO divided by prescaler times main plus swallow
// R10 - Prescaler ratios only 16/17 or 32/33
// R11 - Mode bit low 16/17, high 32/33
// R12 - Host keeps swallow count 0 to 127
// R13 - Host keeps main count 3 to 2047
// R14 - Power bit low: synthesizer off, dividers cleared
// R15 - Pins 00: power-down, dividers hold contents
// R16 - Pins 11: receive, synthesizer active
// R17 - Pin one high, two low: transmit
// R18 - Pin one low, two high: idle, active
// R19 - Shifter keeps last twenty bits only
`timescale 1ns/1ps
module ssp_device
(
  ssp_link_if.dev link,
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic REF_IN,
  input wire logic LO_IN,
  output logic [19:0] REF_WORD_OUT,
  output logic [19:0] LOOP_WORD_OUT,
  output logic [19:0] MODE_WORD_OUT,
  output logic [19:0] OFFSET_WORD_OUT,
  output logic LOAD_DONE_OUT,
  output ssp_pkg::ssp_pwr_type PWR_STATE_OUT,
  output logic SYNTH_ACTIVE_OUT,
  output logic REF_PULSE_OUT,
  output logic LO_PULSE_OUT
);

  // ==========================================================
  // Link domain shifter
  logic [19:0] shift_r;
  logic [19:0] shift_nxt;

  always_comb
  begin
    shift_nxt = shift_r;
    if (!link.load_strobe) // see R2
    begin
      shift_nxt = {shift_r[18:0], link.sdata}; // see R1, see R19
    end
  end

  always_ff @(posedge link.sclk)
  begin
    shift_r <= shift_nxt;
  end

  // ==========================================================
  // Synchronisers
  logic le_s1_r, le_s2_r, le_s3_r;
  logic [1:0] pe_s1_r, pe_s2_r;
  logic [2:0] ref_s_r, lo_s_r;

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      le_s1_r <= 1'b1;
      le_s2_r <= 1'b1;
      le_s3_r <= 1'b1;
      pe_s1_r <= 2'h0;
      pe_s2_r <= 2'h0;
      ref_s_r <= 3'h0;
      lo_s_r <= 3'h0;
    end
    else if (CE_IN)
    begin
      le_s1_r <= link.load_strobe;
      le_s2_r <= le_s1_r;
      le_s3_r <= le_s2_r;
      pe_s1_r <= {link.power_enable_pin_one, link.power_enable_pin_two};
      pe_s2_r <= pe_s1_r;
      ref_s_r <= {ref_s_r[1:0], REF_IN};
      lo_s_r <= {lo_s_r[1:0], LO_IN};
    end
  end

  // ==========================================================
  // Control words
  logic [19:0] ref_word_r, ref_word_nxt;
  logic [19:0] loop_word_r, loop_word_nxt;
  logic [19:0] mode_word_r, mode_word_nxt;
  logic [19:0] offs_word_r, offs_word_nxt;
  logic load_done_r, load_done_nxt;

  // Shifter is stable here: the host stops the serial clock while the strobe is high
  always_comb
  begin
    ref_word_nxt = ref_word_r;
    loop_word_nxt = loop_word_r;
    mode_word_nxt = mode_word_r;
    offs_word_nxt = offs_word_r;
    load_done_nxt = 1'b0;
    if (ssp_pkg::rise(le_s3_r, le_s2_r)) // see R3
    begin
      load_done_nxt = 1'b1;
      unique case (ssp_pkg::sel_of(shift_r)) // see R4
        ssp_pkg::SEL_REF: ref_word_nxt = shift_r;
        ssp_pkg::SEL_LOOP: loop_word_nxt = shift_r;
        ssp_pkg::SEL_MODE: mode_word_nxt = shift_r;
        ssp_pkg::SEL_OFFS: offs_word_nxt = shift_r;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      ref_word_r <= ssp_pkg::WORD_RST;
      loop_word_r <= ssp_pkg::WORD_RST;
      mode_word_r <= ssp_pkg::WORD_RST;
      offs_word_r <= ssp_pkg::WORD_RST;
      load_done_r <= 1'b0;
    end
    else if (CE_IN)
    begin
      ref_word_r <= ref_word_nxt;
      loop_word_r <= loop_word_nxt;
      mode_word_r <= mode_word_nxt;
      offs_word_r <= offs_word_nxt;
      load_done_r <= load_done_nxt;
    end
  end

  // ==========================================================
  // Power state and dividers
  ssp_pkg::ssp_pwr_type pwr_r, pwr_nxt;
  logic active_r, active_nxt;
  logic [14:0] ref_cnt_r, ref_cnt_nxt;
  logic [16:0] lo_cnt_r, lo_cnt_nxt;
  logic ref_pulse_r, ref_pulse_nxt;
  logic lo_pulse_r, lo_pulse_nxt;
  logic [14:0] ref_ratio;
  logic [6:0] swallow;
  logic [10:0] main_cnt;
  logic [16:0] lo_ratio;

  assign ref_ratio = ref_word_r[ssp_pkg::REF_LSB +: ssp_pkg::REF_W]; // see R6
  assign swallow = loop_word_r[ssp_pkg::SWAL_LSB +: ssp_pkg::SWAL_W]; // see R8
  assign main_cnt = loop_word_r[ssp_pkg::MAIN_LSB +: ssp_pkg::MAIN_W]; // see R8
  // Only two prescaler settings exist; select bit low picks the smaller
  assign lo_ratio = 17'(17'(main_cnt) * (mode_word_r[ssp_pkg::MODE_PSC_POS] ?
    17'(ssp_pkg::PSC_HIGH) : 17'(ssp_pkg::PSC_LOW))) + 17'(swallow); // see R9, R10, R11

  always_comb
  begin
    pwr_nxt = ssp_pkg::PWR_OFF; // see R14
    if (mode_word_r[ssp_pkg::MODE_PWR_POS])
    begin
      unique case (pe_s2_r)
        2'h0: pwr_nxt = ssp_pkg::PWR_DOWN; // see R15
        2'h3: pwr_nxt = ssp_pkg::PWR_RX; // see R16
        2'h2: pwr_nxt = ssp_pkg::PWR_TX; // see R17
        2'h1: pwr_nxt = ssp_pkg::PWR_IDLE; // see R18
      endcase
    end
    active_nxt = (pwr_nxt != ssp_pkg::PWR_OFF) && (pwr_nxt != ssp_pkg::PWR_DOWN);
    ref_cnt_nxt = ref_cnt_r;
    lo_cnt_nxt = lo_cnt_r;
    ref_pulse_nxt = 1'b0;
    lo_pulse_nxt = 1'b0;
    if (pwr_r == ssp_pkg::PWR_OFF)
    begin
      ref_cnt_nxt = 15'h0000; // see R14
      lo_cnt_nxt = 17'h00000;
    end
    else if (active_r) // see R15
    begin
      if (ssp_pkg::rise(ref_s_r[2], ref_s_r[1]))
      begin
        if (16'(ref_cnt_r) + 16'h0001 >= 16'(ref_ratio)) // see R6
        begin
          ref_cnt_nxt = 15'h0000;
          ref_pulse_nxt = 1'b1;
        end
        else
        begin
          ref_cnt_nxt = ref_cnt_r + 15'h0001;
        end
      end
      if (ssp_pkg::rise(lo_s_r[2], lo_s_r[1]))
      begin
        if (18'(lo_cnt_r) + 18'h00001 >= 18'(lo_ratio)) // see R9
        begin
          lo_cnt_nxt = 17'h00000;
          lo_pulse_nxt = 1'b1;
        end
        else
        begin
          lo_cnt_nxt = lo_cnt_r + 17'h00001;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      pwr_r <= ssp_pkg::PWR_OFF;
      active_r <= 1'b0;
      ref_cnt_r <= 15'h0000;
      lo_cnt_r <= 17'h00000;
      ref_pulse_r <= 1'b0;
      lo_pulse_r <= 1'b0;
    end
    else if (CE_IN)
    begin
      pwr_r <= pwr_nxt;
      active_r <= active_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      ref_pulse_r <= ref_pulse_nxt;
      lo_pulse_r <= lo_pulse_nxt;
    end
  end

  assign REF_WORD_OUT = ref_word_r;
  assign LOOP_WORD_OUT = loop_word_r;
  assign MODE_WORD_OUT = mode_word_r;
  assign OFFSET_WORD_OUT = offs_word_r;
  assign LOAD_DONE_OUT = load_done_r;
  assign PWR_STATE_OUT = pwr_r;
  assign SYNTH_ACTIVE_OUT = active_r;
  assign REF_PULSE_OUT = ref_pulse_r;
  assign LO_PULSE_OUT = lo_pulse_r;

endmodule // ssp_device

/* ssp_host.sv */
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module ssp_host #(
  parameter int HALF_CYC = ssp_pkg::SCLK_HALF_CYC
)
(
  ssp_link_if.host link,
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT
);

  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} ssp_host_st_type;

  // ==========================================================
  // Bus slave and serial engine
  ssp_host_st_type st_r, st_nxt;
  logic [7:0] tick_r, tick_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [19:0] tx_r, tx_nxt;
  logic [19:0] word_r, word_nxt;
  logic sclk_r, sclk_nxt;
  logic sdata_r, sdata_nxt;
  logic le_r, le_nxt;
  logic [1:0] pe_r, pe_nxt;
  logic mode_loaded_r, mode_loaded_nxt;
  logic refused_r, refused_nxt;
  logic dph_r, dph_nxt;
  logic dwr_r, dwr_nxt;
  logic [7:0] daddr_r, daddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic busy;
  logic legal;
  logic half_done;
  logic [19:0] wword;

  assign busy = (st_r != ST_IDLE);
  assign half_done = (tick_r == 8'(HALF_CYC - 1));
  assign wword = HWDATA_IN[19:0];

  // Range and ordering guards keep the far end inside its supported settings
  always_comb
  begin
    legal = 1'b1;
    if (!mode_loaded_r && ssp_pkg::sel_of(wword) != ssp_pkg::SEL_MODE)
    begin
      legal = 1'b0; // see R5
    end
    if (ssp_pkg::sel_of(wword) == ssp_pkg::SEL_REF &&
        wword[ssp_pkg::REF_LSB +: ssp_pkg::REF_W] < ssp_pkg::REF_MIN)
    begin
      legal = 1'b0; // see R7
    end
    if (ssp_pkg::sel_of(wword) == ssp_pkg::SEL_LOOP &&
        wword[ssp_pkg::MAIN_LSB +: ssp_pkg::MAIN_W] < ssp_pkg::MAIN_MIN)
    begin
      legal = 1'b0; // see R13; 7-bit swallow field is always in range, see R12
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    tick_nxt = tick_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    word_nxt = word_r;
    sclk_nxt = sclk_r;
    sdata_nxt = sdata_r;
    le_nxt = le_r;
    pe_nxt = pe_r;
    mode_loaded_nxt = mode_loaded_r;
    refused_nxt = refused_r;
    dph_nxt = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    dwr_nxt = HWRITE_IN;
    daddr_nxt = HADDR_IN[7:0];
    rdata_nxt = rdata_r;
    if (dph_nxt && !HWRITE_IN)
    begin
      unique case (HADDR_IN[7:0])
        ssp_pkg::OFS_WORD: rdata_nxt = {12'h000, word_r};
        ssp_pkg::OFS_STATUS: rdata_nxt = {29'h00000000, refused_r, mode_loaded_r, busy};
        ssp_pkg::OFS_CTRL: rdata_nxt = {30'h00000000, pe_r[0], pe_r[1]};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
    unique case (st_r)
      ST_IDLE:
      begin
        tick_nxt = 8'h00;
      end
      ST_LOW:
      begin
        tick_nxt = tick_r + 8'h01;
        if (half_done)
        begin
          tick_nxt = 8'h00;
          sclk_nxt = 1'b1; // see R1
          st_nxt = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        tick_nxt = tick_r + 8'h01;
        if (half_done)
        begin
          tick_nxt = 8'h00;
          sclk_nxt = 1'b0;
          if (bit_r == 5'h00)
          begin
            st_nxt = ST_TAIL;
          end
          else
          begin
            bit_nxt = bit_r - 5'h01;
            tx_nxt = {tx_r[18:0], 1'b0};
            sdata_nxt = tx_r[18]; // see R1
            st_nxt = ST_LOW;
          end
        end
      end
      ST_TAIL:
      begin
        tick_nxt = tick_r + 8'h01;
        if (half_done)
        begin
          tick_nxt = 8'h00;
          le_nxt = 1'b1; // see R3
          st_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        tick_nxt = tick_r + 8'h01;
        if (half_done)
        begin
          tick_nxt = 8'h00;
          st_nxt = ST_IDLE;
        end
      end
    endcase
    if (dph_r && dwr_r && daddr_r == ssp_pkg::OFS_CTRL)
    begin
      pe_nxt = {HWDATA_IN[ssp_pkg::CTRL_PE1_POS], HWDATA_IN[ssp_pkg::CTRL_PE2_POS]};
    end
    if (dph_r && dwr_r && daddr_r == ssp_pkg::OFS_WORD)
    begin
      if (busy || !legal)
      begin
        refused_nxt = 1'b1;
      end
      else
      begin
        refused_nxt = 1'b0;
        word_nxt = wword;
        tx_nxt = wword;
        sdata_nxt = wword[19];
        bit_nxt = 5'(ssp_pkg::WORD_W - 1);
        le_nxt = 1'b0; // see R2
        tick_nxt = 8'h00;
        st_nxt = ST_LOW;
        if (ssp_pkg::sel_of(wword) == ssp_pkg::SEL_MODE)
        begin
          mode_loaded_nxt = 1'b1; // see R5
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      st_r <= ST_IDLE;
      tick_r <= 8'h00;
      bit_r <= 5'h00;
      tx_r <= ssp_pkg::WORD_RST;
      word_r <= ssp_pkg::WORD_RST;
      sclk_r <= 1'b0;
      sdata_r <= 1'b0;
      le_r <= 1'b1;
      pe_r <= 2'h0;
      mode_loaded_r <= 1'b0;
      refused_r <= 1'b0;
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      daddr_r <= 8'h00;
      rdata_r <= 32'h00000000;
    end
    else if (CE_IN)
    begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      word_r <= word_nxt;
      sclk_r <= sclk_nxt;
      sdata_r <= sdata_nxt;
      le_r <= le_nxt;
      pe_r <= pe_nxt;
      mode_loaded_r <= mode_loaded_nxt;
      refused_r <= refused_nxt;
      dph_r <= dph_nxt;
      dwr_r <= dwr_nxt;
      daddr_r <= daddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.sdata = sdata_r;
  assign link.load_strobe = le_r;
  assign link.power_enable_pin_one = pe_r[1];
  assign link.power_enable_pin_two = pe_r[0];
  assign HRDATA_OUT = rdata_r;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

endmodule // ssp_host

/* ssp_link_asserts.sv */
`timescale 1ns/1ps
module ssp_link_asserts
(
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe
);
  // ==========================================================
  // Frame tracking
  logic sclk_d_r;
  logic mode_seen_r;
  logic mode_seen_nxt;
  logic [4:0] bits_r;
  logic [4:0] bits_nxt;
  logic [1:0] last_r;
  logic [1:0] last_nxt;
  logic sclk_rise;

  assign sclk_rise = sclk & ~sclk_d_r;

  always_comb
  begin
    bits_nxt = bits_r;
    last_nxt = last_r;
    mode_seen_nxt = mode_seen_r;
    if (load_strobe)
      bits_nxt = 5'h00;
    else if (sclk_rise)
    begin
      bits_nxt = bits_r + 5'h01;
      last_nxt = {last_r[0], sdata};
    end
    // Only a whole word with select 10 counts as a mode load
    if (load_strobe && bits_r == 5'h14 && last_r == 2'h1)
      mode_seen_nxt = 1'b1;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      sclk_d_r <= 1'b0;
      bits_r <= 5'h00;
      last_r <= 2'h0;
      mode_seen_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk;
      bits_r <= bits_nxt;
      last_r <= last_nxt;
      mode_seen_r <= mode_seen_nxt;
    end
  end

  // ==========================================================
  // Link rules
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  a_sclk_still_idle: assert property (load_strobe |-> !sclk)
    else $error("serial clock high outside a frame");
  a_sdata_hold_high: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while clock high");
  a_sdata_setup: assert property ($rose(sclk) |-> sdata == $past(sdata, 2))
    else $error("serial data not set up before clock rise");
  a_sclk_high_width: assert property ($rose(sclk) |-> sclk[*2] ##1 !sclk)
    else $error("serial clock high width wrong");
  a_word_len_twenty: assert property ($rose(load_strobe) |-> bits_r == 5'h14)
    else $error("frame did not carry twenty bits");
  a_count_bounded: assert property (!load_strobe |-> bits_r <= 5'h14)
    else $error("more than twenty bits in one frame");
  a_mode_first: assert property ($rose(load_strobe) && !mode_seen_r |-> last_r == 2'h1)
    else $error("first word after reset is not a mode word");
  a_strobe_gap: assert property ($rose(load_strobe) |=> load_strobe[*2])
    else $error("strobe high gap too short");
  a_frame_ends: assert property ($fell(load_strobe) |-> ##[60:200] $rose(load_strobe))
    else $error("frame did not close in time");
endmodule // ssp_link_asserts

/* ssp_link_if.sv */
`timescale 1ns/1ps
interface ssp_link_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  logic power_enable_pin_one;
  logic power_enable_pin_two;

  modport host
  (
    output sclk,
    output sdata,
    output load_strobe,
    output power_enable_pin_one,
    output power_enable_pin_two
  );

  modport dev
  (
    input sclk,
    input sdata,
    input load_strobe,
    input power_enable_pin_one,
    input power_enable_pin_two
  );
endinterface

/* ssp_pkg.sv */
package ssp_pkg;

  // ==========================================================
  // Serial word layout
  localparam int WORD_W = 20;
  localparam int SEL_HI_POS = 0;
  localparam int SEL_LO_POS = 1;
  localparam int REF_LSB = 2;
  localparam int REF_W = 15;
  localparam int SWAL_LSB = 2;
  localparam int SWAL_W = 7;
  localparam int MAIN_LSB = 9;
  localparam int MAIN_W = 11;
  localparam int LOOP_N_W = 17;
  localparam int MODE_PWR_POS = 2;
  localparam int MODE_PSC_POS = 4;
  localparam logic [19:0] WORD_RST = 20'h00000;

  typedef enum logic [1:0]
  {
    SEL_REF = 2'h0,
    SEL_LOOP = 2'h1,
    SEL_MODE = 2'h2,
    SEL_OFFS = 2'h3
  } ssp_sel_type;

  // ==========================================================
  // Divider ranges and prescaler ratios
  localparam int PSC_LOW = 16;
  localparam int PSC_HIGH = 32;
  localparam logic [14:0] REF_MIN = 15'h0003;
  localparam logic [10:0] MAIN_MIN = 11'h003;

  // ==========================================================
  // Power states
  typedef enum logic [2:0] {PWR_OFF, PWR_DOWN, PWR_IDLE, PWR_RX, PWR_TX} ssp_pwr_type;

  // ==========================================================
  // Link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MIN_WIDTH_NS = 20;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Controller registers
  localparam logic [7:0] OFS_WORD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_MODE_POS = 1;
  localparam int ST_REFUSED_POS = 2;
  localparam int CTRL_PE1_POS = 0;
  localparam int CTRL_PE2_POS = 1;

  // Select code: first select position is the last bit shifted in
  function automatic ssp_sel_type sel_of(input logic [19:0] w);
    sel_of = ssp_sel_type'({w[SEL_HI_POS], w[SEL_LO_POS]});
  endfunction

  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction

endpackage

/* synth_serial_program_port_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module synth_serial_program_port_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ref_in = 1'b0;
  logic lo_in = 1'b0;
  logic dev_ce = 1'b1;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic load_done;
  logic synth_on;
  logic ref_pulse;
  logic lo_pulse;
  logic [19:0] ref_w;
  logic [19:0] loop_w;
  logic [19:0] mode_w;
  logic [19:0] offs_w;
  ssp_pkg::ssp_pwr_type pwr;
  int bad_count = 0;
  int compares = 0;
  int ref_n = 0;
  int lo_n = 0;
  int done_n = 0;

  always #5 clk = ~clk;

  ssp_link_if ssp_link_if_i ();
  ssp_host ssp_host_i (.link(ssp_link_if_i), .CLOCK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp));
  ssp_device ssp_device_i (.link(ssp_link_if_i), .CLOCK_IN(clk), .RSTN_IN(rstn),
    .CE_IN(dev_ce), .REF_IN(ref_in), .LO_IN(lo_in), .REF_WORD_OUT(ref_w),
    .LOOP_WORD_OUT(loop_w), .MODE_WORD_OUT(mode_w), .OFFSET_WORD_OUT(offs_w),
    .LOAD_DONE_OUT(load_done), .PWR_STATE_OUT(pwr), .SYNTH_ACTIVE_OUT(synth_on),
    .REF_PULSE_OUT(ref_pulse), .LO_PULSE_OUT(lo_pulse));
  ssp_link_asserts ssp_link_asserts_i (.CLOCK_IN(clk), .RSTN_IN(rstn),
    .sclk(ssp_link_if_i.sclk), .sdata(ssp_link_if_i.sdata),
    .load_strobe(ssp_link_if_i.load_strobe));

  // ==========================================================
  // Pulse counters, read as differences by the tests
  always @(posedge clk)
  begin
    ref_n <= ref_n + (ref_pulse === 1'b1 ? 1 : 0);
    lo_n <= lo_n + (lo_pulse === 1'b1 ? 1 : 0);
    done_n <= done_n + (load_done === 1'b1 ? 1 : 0);
  end

  // ==========================================================
  // Bus and link tasks
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h00000000, d);
    `CHK(n, e, d)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // Polls busy; a refused word never raises it, so the loop ends at once
  task automatic send(input logic [31:0] w);
    logic [31:0] s;
    ahb(1'b1, ssp_pkg::OFS_WORD, w, s);
    // A stuck busy flag is caught by the watchdog
    do
      ahb(1'b0, ssp_pkg::OFS_STATUS, 32'h00000000, s);
    while (s[0] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask

  task automatic pins_chk(input logic [1:0] p, input ssp_pkg::ssp_pwr_type e, input logic a);
    logic [31:0] x;
    ahb(1'b1, ssp_pkg::OFS_CTRL, {30'h00000000, p}, x);
    repeat (8) @(posedge clk);
    `CHK("pwr_state", e, pwr)
    `CHK("synth_active", a, synth_on)
    rd_chk("ctrl_rb", ssp_pkg::OFS_CTRL, {30'h00000000, p});
  endtask

  // Inputs kept slow so the two-flop synchronisers see every edge
  task automatic toggle(input int n);
    repeat (n)
    begin
      ref_in <= 1'b1;
      lo_in <= 1'b1;
      repeat (2) @(posedge clk);
      ref_in <= 1'b0;
      lo_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_order();
    int d0;
    rd_chk("status_rst", ssp_pkg::OFS_STATUS, 32'h00000000);
    rd_chk("unmapped", 8'h0C, 32'h00000000);
    `CHK("pwr_rst", ssp_pkg::PWR_OFF, pwr)
    d0 = done_n;
    send(32'h00000014);
    rd_chk("status_refused", ssp_pkg::OFS_STATUS, 32'h00000004);
    `CHK("ref_untouched", 20'h00000, ref_w)
    `CHK("no_latch", d0, done_n)
    $display("test order done");
  endtask

  task automatic test_modes();
    int d0;
    d0 = done_n;
    send(32'h00000005);
    `CHK("mode_word", 20'h00005, mode_w)
    `CHK("load_done", 1, done_n - d0)
    rd_chk("word_rb", ssp_pkg::OFS_WORD, 32'h00000005);
    rd_chk("status_mode", ssp_pkg::OFS_STATUS, 32'h00000002);
    pins_chk(2'h0, ssp_pkg::PWR_DOWN, 1'b0);
    pins_chk(2'h1, ssp_pkg::PWR_TX, 1'b1);
    pins_chk(2'h2, ssp_pkg::PWR_IDLE, 1'b1);
    pins_chk(2'h3, ssp_pkg::PWR_RX, 1'b1);
    $display("test modes done");
  endtask

  task automatic test_dividers();
    int r0;
    int l0;
    send(32'h00000014);
    `CHK("ref_word", 20'h00014, ref_w)
    send(32'h0000060A);
    `CHK("loop_word", 20'h0060A, loop_w)
    send(32'h00000008);
    `CHK("ref_low_kept", 20'h00014, ref_w)
    send(32'h00000402);
    `CHK("main_low_kept", 20'h0060A, loop_w)
    r0 = ref_n;
    l0 = lo_n;
    toggle(100);
    `CHK("ref_pulses", 20, ref_n - r0)
    `CHK("lo_pulses_16", 2, lo_n - l0)
    send(32'h00000015);
    r0 = ref_n;
    l0 = lo_n;
    toggle(196);
    `CHK("ref_pulses_b", 39, ref_n - r0)
    `CHK("lo_pulses_32", 2, lo_n - l0)
    $display("test dividers done");
  endtask

  task automatic test_offset_off();
    int r0;
    send(32'hFFFABCD7);
    `CHK("offset_word", 20'hABCD7, offs_w)
    send(32'h00000001);
    pins_chk(2'h3, ssp_pkg::PWR_OFF, 1'b0);
    r0 = ref_n + lo_n;
    toggle(20);
    `CHK("off_no_pulses", r0, ref_n + lo_n)
    $display("test offset and power off done");
  endtask

  // Device clock enable low: pins and divider inputs must leave no trace until it is raised again
  task automatic test_freeze();
    logic [31:0] x;
    int r0;
    dev_ce <= 1'b0;
    ahb(1'b1, ssp_pkg::OFS_CTRL, 32'h00000000, x);
    r0 = ref_n + lo_n;
    toggle(10);
    `CHK("frozen_pwr", ssp_pkg::PWR_RX, pwr)
    `CHK("frozen_no_pulses", r0, ref_n + lo_n)
    dev_ce <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("thawed_pwr", ssp_pkg::PWR_DOWN, pwr)
    $display("test freeze done");
  endtask

  initial
  begin
    #300000;
    bad_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    test_order();
    test_modes();
    test_dividers();
    test_freeze();
    test_offset_off();
    finish_test();
  end
endmodule // synth_serial_program_port_test
